// ===== dcs_sideband_regs.sv
/*
  dcs_sideband_regs: APB register bank holding read-only DRAM timing and
  geometry words plus the sideband request and status registers.
  Assumes pclk also clocks the command scheduler, so its status inputs
  need no synchroniser, and that the timing inputs are stable.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module dcs_sideband_regs (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire dcs_pkg::dcs_timing_t   timing_cfg,
  input  wire dcs_pkg::dcs_geometry_t geometry_cfg,
  input  wire dcs_pkg::dcs_status_t   sched_status,
  output dcs_pkg::dcs_cmd_t          sched_cmd
);
  import dcs_pkg::*;

  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        mr_pending_reg;
  logic [2:0]  kind_reg;
  logic [3:0]  mask_reg;
  logic [31:0] payload_reg;
  logic [3:0]  refresh_req_reg;
  logic [3:0]  sr_bits_reg;
  logic        sr_out_reg;
  logic [7:0]  arf_cnt_reg;
  logic [9:0]  idx;
  logic        answer;
  logic        commit;

  // address decode shared by the read path and every write
  function automatic logic is_mapped(input logic [9:0] i);
    unique case (i)
      IDX_ACTIVATE_TIMING, IDX_READ_TURNAROUND, IDX_READ_WRITE_MIX,
      IDX_WRITE_TURNAROUND, IDX_PRECHARGE_REFRESH, IDX_FOUR_ACTIVATE_WINDOW,
      IDX_MEMORY_GEOMETRY, IDX_MODE_REG_CMD_REQUEST, IDX_RANK_REFRESH_REQUEST,
      IDX_SELF_REFRESH_REQUEST, IDX_MODE_REG_CMD_BUSY, IDX_REFRESH_IN_PROGRESS,
      IDX_SELF_REFRESH_ACTIVE, IDX_POWER_DOWN_ACTIVE, IDX_MODE_REG_CMD_DESC,
      IDX_MODE_REG_CMD_PAYLOAD: is_mapped = 1'b1;
      default:                  is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // read word assembly; unnamed bits are zero-filled
  function automatic logic [31:0] read_word(input logic [9:0] i);
    unique case (i)
      IDX_ACTIVATE_TIMING: read_word = {2'h0, timing_cfg.act_diff_bg,
        timing_cfg.act_diff_bank, timing_cfg.act_same_bank,
        timing_cfg.act_to_pch, timing_cfg.act_to_access_delay};
      IDX_READ_TURNAROUND: read_word = {2'h0, timing_cfg.rd_wr_diff_chip,
        timing_cfg.rd_wr_same, timing_cfg.rd_rd_diff_bg,
        timing_cfg.rd_rd_diff_chip, timing_cfg.rd_rd_same};
      IDX_READ_WRITE_MIX: read_word = {2'h0, timing_cfg.wr_wr_diff_chip,
        timing_cfg.wr_wr_same, timing_cfg.rd_ap_to_valid,
        timing_cfg.rd_to_pch, timing_cfg.rd_wr_diff_bg};
      IDX_WRITE_TURNAROUND: read_word = {2'h0, timing_cfg.wr_to_pch,
        timing_cfg.wr_rd_diff_bg, timing_cfg.wr_rd_diff_chip,
        timing_cfg.wr_to_rd, timing_cfg.wr_wr_diff_bg};
      IDX_PRECHARGE_REFRESH: read_word = {timing_cfg.powerdown_exit_delay,
        timing_cfg.auto_refresh_recovery, timing_cfg.pch_all_to_valid,
        timing_cfg.pch_to_valid, timing_cfg.wr_ap_to_valid};
      IDX_FOUR_ACTIVATE_WINDOW:
        read_word = {24'h00_0000, timing_cfg.four_activate_window_len};
      IDX_MEMORY_GEOMETRY: read_word = {13'h0000, geometry_cfg};
      IDX_MODE_REG_CMD_REQUEST: read_word = {31'h0000_0000, mr_pending_reg};
      IDX_RANK_REFRESH_REQUEST: read_word = {28'h000_0000, refresh_req_reg};
      IDX_SELF_REFRESH_REQUEST: read_word = {28'h000_0000, sr_bits_reg};
      IDX_MODE_REG_CMD_BUSY: read_word = {31'h0000_0000, mr_pending_reg};
      IDX_REFRESH_IN_PROGRESS: read_word = {31'h0000_0000, arf_cnt_reg != RST_COUNT};
      IDX_SELF_REFRESH_ACTIVE:
        read_word = {31'h0000_0000, sched_status.self_refresh_state};
      IDX_POWER_DOWN_ACTIVE:
        read_word = {31'h0000_0000, sched_status.powerdown_active};
      IDX_MODE_REG_CMD_DESC: read_word = {25'h000_0000, mask_reg, kind_reg};
      IDX_MODE_REG_CMD_PAYLOAD: read_word = payload_reg;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // word index and the two bus phases that matter
  assign idx    = paddr[11:2];
  assign answer = psel & penable & ~pready_reg;
  assign commit = psel & penable & pready_reg & pwrite & is_mapped(idx);

  // one wait state: pready rises in the second access cycle, then falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= answer;
      pslverr_reg <= answer & ~is_mapped(idx);
    end
  end

  // read data is captured with pready; unmapped or write cycles return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (answer && !pwrite && is_mapped(idx)) begin
      prdata_reg <= read_word(idx);
    end else begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  // command request: a fresh request beats a completion in the same cycle;
  // reserved kinds are refused so the scheduler never gets a request carrying one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_pending_reg <= 1'b0;
    end else if (commit && idx == IDX_MODE_REG_CMD_REQUEST && pwdata[0]
                 && kind_reg == KIND_MODE_REGISTER_SET) begin
      mr_pending_reg <= 1'b1;
    end else if (sched_status.moderegister_done) begin
      mr_pending_reg <= 1'b0;
    end
  end

  // descriptor words; frozen while a command is pending so the scheduler
  // never sees them change mid-command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_reg    <= RST_KIND;
      mask_reg    <= RST_MASK;
      payload_reg <= RST_PAYLOAD;
    end else if (commit && !mr_pending_reg) begin
      if (idx == IDX_MODE_REG_CMD_DESC) begin
        kind_reg <= pwdata[KIND_LSB +: 3];
        mask_reg <= pwdata[MASK_LSB +: 4];
      end
      if (idx == IDX_MODE_REG_CMD_PAYLOAD) begin
        payload_reg <= pwdata;
      end
    end
  end

  // per-rank refresh requests: writing 1 sets, hardware completion clears,
  // writing 0 has no effect; set wins over a clear in the same cycle
  generate
    for (genvar r = 0; r < 4; r++) begin : g_rank
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          refresh_req_reg[r] <= 1'b0;
        end else if (commit && idx == IDX_RANK_REFRESH_REQUEST && pwdata[r]) begin
          refresh_req_reg[r] <= 1'b1;
        end else if (sched_status.refresh_done[r]) begin
          refresh_req_reg[r] <= 1'b0;
        end
      end
    end
  endgenerate

  // self-refresh request bits are plain software state; the request stays
  // asserted while any bit is set, so a split write cannot exit early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_bits_reg <= RST_RANKS;
      sr_out_reg  <= 1'b0;
    end else begin
      if (commit && idx == IDX_SELF_REFRESH_REQUEST) begin
        sr_bits_reg <= pwdata[3:0];
      end
      sr_out_reg <= |sr_bits_reg;
    end
  end

  // refresh recovery window: load the programmed count on issue, count down;
  // a refresh programmed with a zero window never reads as in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arf_cnt_reg <= RST_COUNT;
    end else if (sched_status.refresh_issued) begin
      arf_cnt_reg <= timing_cfg.auto_refresh_recovery;
    end else if (arf_cnt_reg != RST_COUNT) begin
      arf_cnt_reg <= arf_cnt_reg - 8'h01;
    end
  end

  // every output is a flop
  assign prdata                            = prdata_reg;
  assign pready                            = pready_reg;
  assign pslverr                           = pslverr_reg;
  assign sched_cmd.moderegister_go          = mr_pending_reg;
  assign sched_cmd.moderegister_kind        = kind_reg;
  assign sched_cmd.moderegister_target_mask = mask_reg;
  assign sched_cmd.moderegister_payload     = payload_reg;
  assign sched_cmd.refresh_req              = refresh_req_reg;
  assign sched_cmd.self_refresh_req         = sr_out_reg;

  // read of the activate word returns the live timing fields
  property p_act_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_ACTIVATE_TIMING) |=>
        prdata == {2'h0, $past(timing_cfg.act_diff_bg), $past(timing_cfg.act_diff_bank),
                   $past(timing_cfg.act_same_bank), $past(timing_cfg.act_to_pch),
                   $past(timing_cfg.act_to_access_delay)} && pready;
  endproperty
  a_act_read: assert property (p_act_read) else $error("activate word misread");

  // chip-select width lands at bits 18:16 and the upper bits read zero
  property p_geom_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_MEMORY_GEOMETRY) |=>
        prdata[18:16] == $past(geometry_cfg.cs_width) && prdata[31:19] == 13'h0000;
  endproperty
  a_geom_read: assert property (p_geom_read) else $error("geometry word misread");

  // an accepted command request is visible to the scheduler on the next cycle
  property p_mr_go;
    @(posedge pclk) disable iff (!presetn)
      (commit && idx == IDX_MODE_REG_CMD_REQUEST && pwdata[0] && kind_reg == 3'h0)
        |=> sched_cmd.moderegister_go;
  endproperty
  a_mr_go: assert property (p_mr_go) else $error("command request lost");

  // completion without a new request drops the busy status
  property p_mr_done;
    @(posedge pclk) disable iff (!presetn)
      (sched_status.moderegister_done && !(commit && idx == IDX_MODE_REG_CMD_REQUEST))
        |=> !sched_cmd.moderegister_go;
  endproperty
  a_mr_done: assert property (p_mr_done) else $error("command busy not cleared");

  // a reserved kind never reaches the scheduler as a new request
  property p_kind_refused;
    @(posedge pclk) disable iff (!presetn)
      $rose(sched_cmd.moderegister_go) |-> sched_cmd.moderegister_kind == 3'h0;
  endproperty
  a_kind_refused: assert property (p_kind_refused) else $error("reserved kind issued");

  // a refresh issue loads the programmed recovery count
  property p_arf_window;
    @(posedge pclk) disable iff (!presetn)
      sched_status.refresh_issued |=> arf_cnt_reg == $past(timing_cfg.auto_refresh_recovery);
  endproperty
  a_arf_window: assert property (p_arf_window) else $error("refresh window wrong");

  // a rank 0 completion without a new write clears the rank 0 request
  property p_rank_clear;
    @(posedge pclk) disable iff (!presetn)
      (sched_status.refresh_done[0] && !(commit && idx == IDX_RANK_REFRESH_REQUEST))
        |=> !sched_cmd.refresh_req[0];
  endproperty
  a_rank_clear: assert property (p_rank_clear) else $error("rank request not cleared");

  // self-refresh request follows the software bits two cycles after a write
  property p_sr_hold;
    @(posedge pclk) disable iff (!presetn)
      (commit && idx == IDX_SELF_REFRESH_REQUEST) |=> ##1
        sched_cmd.self_refresh_req == (|$past(pwdata[3:0], 2));
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self-refresh request wrong");

  // power-down status read reports the scheduler level
  property p_pd_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_POWER_DOWN_ACTIVE) |=>
        prdata == {31'h0000_0000, $past(sched_status.powerdown_active)};
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("power-down status wrong");

  // unmapped accesses flag an error and read as zero
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answer wrong");

  // read turnaround word returns the live timing fields
  property p_rdt_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_READ_TURNAROUND) |=>
        prdata == {2'h0, $past(timing_cfg.rd_wr_diff_chip), $past(timing_cfg.rd_wr_same),
                   $past(timing_cfg.rd_rd_diff_bg), $past(timing_cfg.rd_rd_diff_chip),
                   $past(timing_cfg.rd_rd_same)} && pready;
  endproperty
  a_rdt_read: assert property (p_rdt_read) else $error("read turnaround misread");

  // read/write mix word returns the live timing fields
  property p_mix_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_READ_WRITE_MIX) |=>
        prdata == {2'h0, $past(timing_cfg.wr_wr_diff_chip), $past(timing_cfg.wr_wr_same),
                   $past(timing_cfg.rd_ap_to_valid), $past(timing_cfg.rd_to_pch),
                   $past(timing_cfg.rd_wr_diff_bg)} && pready;
  endproperty
  a_mix_read: assert property (p_mix_read) else $error("read/write mix misread");

  // write turnaround word returns the live timing fields
  property p_wrt_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_WRITE_TURNAROUND) |=>
        prdata == {2'h0, $past(timing_cfg.wr_to_pch), $past(timing_cfg.wr_rd_diff_bg),
                   $past(timing_cfg.wr_rd_diff_chip), $past(timing_cfg.wr_to_rd),
                   $past(timing_cfg.wr_wr_diff_bg)} && pready;
  endproperty
  a_wrt_read: assert property (p_wrt_read) else $error("write turnaround misread");

  // precharge and refresh word fills all 32 bits with no gap
  property p_pchr_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_PRECHARGE_REFRESH) |=>
        prdata == {$past(timing_cfg.powerdown_exit_delay),
                   $past(timing_cfg.auto_refresh_recovery), $past(timing_cfg.pch_all_to_valid),
                   $past(timing_cfg.pch_to_valid), $past(timing_cfg.wr_ap_to_valid)} && pready;
  endproperty
  a_pchr_read: assert property (p_pchr_read) else $error("precharge word misread");

  // four-activate window sits in the low byte, the rest reads zero
  property p_faw_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_FOUR_ACTIVATE_WINDOW) |=>
        prdata == {24'h00_0000, $past(timing_cfg.four_activate_window_len)};
  endproperty
  a_faw_read: assert property (p_faw_read) else $error("four-activate word misread");

  // busy word mirrors the request seen by the scheduler
  property p_busy_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_MODE_REG_CMD_BUSY) |=>
        prdata == {31'h0000_0000, $past(sched_cmd.moderegister_go)};
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("command busy misread");

  // without a new issue the recovery count steps down by one
  property p_arf_count;
    @(posedge pclk) disable iff (!presetn)
      (arf_cnt_reg != RST_COUNT && !sched_status.refresh_issued) |=>
        arf_cnt_reg == $past(arf_cnt_reg) - 8'h01;
  endproperty
  a_arf_count: assert property (p_arf_count) else $error("recovery count wrong");

  // refresh-in-progress word is high while the count is running
  property p_rip_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_REFRESH_IN_PROGRESS) |=>
        prdata == {31'h0000_0000, ($past(arf_cnt_reg) != RST_COUNT)};
  endproperty
  a_rip_read: assert property (p_rip_read) else $error("refresh status misread");

  // self-refresh status word reports the scheduler level
  property p_sra_read;
    @(posedge pclk) disable iff (!presetn)
      (answer && !pwrite && idx == IDX_SELF_REFRESH_ACTIVE) |=>
        prdata == {31'h0000_0000, $past(sched_status.self_refresh_state)};
  endproperty
  a_sra_read: assert property (p_sra_read) else $error("self-refresh status wrong");

  // writing 1 to rank bit 0 raises the rank 0 request next cycle
  property p_rank_set;
    @(posedge pclk) disable iff (!presetn)
      (commit && idx == IDX_RANK_REFRESH_REQUEST && pwdata[0]) |=>
        sched_cmd.refresh_req[0];
  endproperty
  a_rank_set: assert property (p_rank_set) else $error("rank request not set");

endmodule : dcs_sideband_regs

// ===== dcs_pkg.sv
/*
  dcs_pkg: constants and carrier types for the DRAM controller timing and
  sideband register bank. Assumes a 32-bit APB register port whose byte
  address is four times the word index given here.
*/
package dcs_pkg;

  // word indexes of the mapped registers
  localparam logic [9:0] IDX_ACTIVATE_TIMING       = 10'h01f;
  localparam logic [9:0] IDX_READ_TURNAROUND       = 10'h020;
  localparam logic [9:0] IDX_READ_WRITE_MIX        = 10'h021;
  localparam logic [9:0] IDX_WRITE_TURNAROUND      = 10'h022;
  localparam logic [9:0] IDX_PRECHARGE_REFRESH     = 10'h023;
  localparam logic [9:0] IDX_FOUR_ACTIVATE_WINDOW  = 10'h028;
  localparam logic [9:0] IDX_MEMORY_GEOMETRY       = 10'h02a;
  localparam logic [9:0] IDX_MODE_REG_CMD_REQUEST  = 10'h02b;
  localparam logic [9:0] IDX_RANK_REFRESH_REQUEST  = 10'h02c;
  localparam logic [9:0] IDX_SELF_REFRESH_REQUEST  = 10'h02f;
  localparam logic [9:0] IDX_MODE_REG_CMD_BUSY     = 10'h031;
  localparam logic [9:0] IDX_REFRESH_IN_PROGRESS   = 10'h032;
  localparam logic [9:0] IDX_SELF_REFRESH_ACTIVE   = 10'h034;
  localparam logic [9:0] IDX_POWER_DOWN_ACTIVE     = 10'h036;
  localparam logic [9:0] IDX_MODE_REG_CMD_DESC     = 10'h037;
  localparam logic [9:0] IDX_MODE_REG_CMD_PAYLOAD  = 10'h038;

  // field positions inside the command descriptor word
  localparam int KIND_LSB = 0;
  localparam int MASK_LSB = 3;

  // accepted command kind; every other code is reserved
  localparam logic [2:0] KIND_MODE_REGISTER_SET = 3'h0;

  // values after reset
  localparam logic [2:0]  RST_KIND    = 3'h0;
  localparam logic [3:0]  RST_MASK    = 4'h0;
  localparam logic [31:0] RST_PAYLOAD = 32'h0000_0000;
  localparam logic [3:0]  RST_RANKS   = 4'h0;
  localparam logic [7:0]  RST_COUNT   = 8'h00;

  // timing values from the controller configuration, packed high field first
  typedef struct packed {
    logic [5:0] act_diff_bg, act_diff_bank, act_same_bank, act_to_pch, act_to_access_delay;
    logic [5:0] rd_wr_diff_chip, rd_wr_same, rd_rd_diff_bg, rd_rd_diff_chip, rd_rd_same;
    logic [5:0] wr_wr_diff_chip, wr_wr_same, rd_ap_to_valid, rd_to_pch, rd_wr_diff_bg;
    logic [5:0] wr_to_pch, wr_rd_diff_bg, wr_rd_diff_chip, wr_to_rd, wr_wr_diff_bg;
    logic [5:0] powerdown_exit_delay;
    logic [7:0] auto_refresh_recovery;
    logic [5:0] pch_all_to_valid, pch_to_valid, wr_ap_to_valid;
    logic [7:0] four_activate_window_len;
  } dcs_timing_t;

  // address widths of the attached memory
  typedef struct packed {
    logic [2:0] cs_width;
    logic [1:0] bank_group_width;
    logic [3:0] bank_width;
    logic [4:0] row_width;
    logic [4:0] col_width;
  } dcs_geometry_t;

  // events and levels reported by the command scheduler
  typedef struct packed {
    logic       refresh_issued;
    logic [3:0] refresh_done;
    logic       moderegister_done;
    logic       self_refresh_state;
    logic       powerdown_active;
  } dcs_status_t;

  // requests handed to the command scheduler
  typedef struct packed {
    logic        moderegister_go;
    logic [2:0]  moderegister_kind;
    logic [3:0]  moderegister_target_mask;
    logic [31:0] moderegister_payload;
    logic [3:0]  refresh_req;
    logic        self_refresh_req;
  } dcs_cmd_t;

endpackage : dcs_pkg

// ===== dcs_sideband_regs_tb_top.sv
/*
  dcs_sideband_regs_tb_top: self-checking bench for the timing and sideband
  register bank. Assumes dcs_pkg is compiled first and that the bench itself
  stands in for the APB master and the command scheduler.
*/
`timescale 1ns/100ps
module dcs_sideband_regs_tb_top;
  import dcs_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  dcs_timing_t   tcfg;
  dcs_geometry_t gcfg;
  dcs_status_t   st;
  dcs_cmd_t      cmd;
  int            n_fail;
  int            total_checks;
  logic [31:0]   rd;
  logic          err;

  dcs_sideband_regs i_dcs_sideband_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timing_cfg(tcfg), .geometry_cfg(gcfg), .sched_status(st), .sched_cmd(cmd));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 32'h0, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("word %0d", idx), rd, exp);
  endtask : rdchk

  task automatic pulse_done(input logic mr, input logic [3:0] rk, input logic iss);
    @(posedge pclk);
    st.moderegister_done <= mr;
    st.refresh_done      <= rk;
    st.refresh_issued    <= iss;
    @(posedge pclk);
    st.moderegister_done <= 1'b0;
    st.refresh_done      <= 4'h0;
    st.refresh_issued    <= 1'b0;
  endtask : pulse_done

  // read-only words packed field by field, writes must not stick
  task automatic t_readonly;
    rdchk(IDX_ACTIVATE_TIMING, {2'h0, tcfg.act_diff_bg, tcfg.act_diff_bank, tcfg.act_same_bank,
      tcfg.act_to_pch, tcfg.act_to_access_delay});
    rdchk(IDX_READ_TURNAROUND, {2'h0, tcfg.rd_wr_diff_chip, tcfg.rd_wr_same, tcfg.rd_rd_diff_bg,
      tcfg.rd_rd_diff_chip, tcfg.rd_rd_same});
    rdchk(IDX_READ_WRITE_MIX, {2'h0, tcfg.wr_wr_diff_chip, tcfg.wr_wr_same, tcfg.rd_ap_to_valid,
      tcfg.rd_to_pch, tcfg.rd_wr_diff_bg});
    rdchk(IDX_WRITE_TURNAROUND, {2'h0, tcfg.wr_to_pch, tcfg.wr_rd_diff_bg, tcfg.wr_rd_diff_chip,
      tcfg.wr_to_rd, tcfg.wr_wr_diff_bg});
    rdchk(IDX_PRECHARGE_REFRESH, {tcfg.powerdown_exit_delay, tcfg.auto_refresh_recovery,
      tcfg.pch_all_to_valid, tcfg.pch_to_valid, tcfg.wr_ap_to_valid});
    rdchk(IDX_FOUR_ACTIVATE_WINDOW, {24'h0, tcfg.four_activate_window_len});
    rdchk(IDX_MEMORY_GEOMETRY, {13'h0, gcfg.cs_width, gcfg.bank_group_width, gcfg.bank_width,
      gcfg.row_width, gcfg.col_width});
    apb(1'b1, IDX_FOUR_ACTIVATE_WINDOW, 32'hffff_ffff);
    rdchk(IDX_FOUR_ACTIVATE_WINDOW, {24'h0, tcfg.four_activate_window_len});
    apb(1'b0, 10'h030, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_readonly

  // mode register command: accepted kind, busy until done, reserved kind refused
  task automatic t_moderegister;
    apb(1'b1, IDX_MODE_REG_CMD_DESC, {25'h0, 4'b0011, KIND_MODE_REGISTER_SET});
    apb(1'b1, IDX_MODE_REG_CMD_PAYLOAD, 32'h0064_2abc);
    apb(1'b1, IDX_MODE_REG_CMD_REQUEST, 32'h1);
    repeat (2) @(posedge pclk);
    chk("go", {31'h0, cmd.moderegister_go}, 32'h1);
    chk("kind", {29'h0, cmd.moderegister_kind}, 32'h0);
    chk("mask", {28'h0, cmd.moderegister_target_mask}, 32'h3);
    chk("payload", cmd.moderegister_payload, 32'h0064_2abc);
    rdchk(IDX_MODE_REG_CMD_BUSY, 32'h1);
    rdchk(IDX_MODE_REG_CMD_REQUEST, 32'h1);
    // descriptor is frozen while the command is pending
    apb(1'b1, IDX_MODE_REG_CMD_DESC, 32'h0000_007f);
    rdchk(IDX_MODE_REG_CMD_DESC, 32'h0000_0018);
    rdchk(IDX_MODE_REG_CMD_PAYLOAD, 32'h0064_2abc);
    pulse_done(1'b1, 4'h0, 1'b0);
    rdchk(IDX_MODE_REG_CMD_REQUEST, 32'h0);
    rdchk(IDX_MODE_REG_CMD_BUSY, 32'h0);
    apb(1'b1, IDX_MODE_REG_CMD_DESC, {25'h0, 4'b1111, 3'h5});
    apb(1'b1, IDX_MODE_REG_CMD_REQUEST, 32'h1);
    rdchk(IDX_MODE_REG_CMD_REQUEST, 32'h0);
  endtask : t_moderegister

  // per-rank refresh bits clear one at a time as each rank is done
  task automatic t_rank_refresh;
    apb(1'b1, IDX_RANK_REFRESH_REQUEST, 32'h5);
    repeat (2) @(posedge pclk);
    chk("refresh req", {28'h0, cmd.refresh_req}, 32'h5);
    pulse_done(1'b0, 4'h1, 1'b0);
    rdchk(IDX_RANK_REFRESH_REQUEST, 32'h4);
    pulse_done(1'b0, 4'h4, 1'b0);
    rdchk(IDX_RANK_REFRESH_REQUEST, 32'h0);
  endtask : t_rank_refresh

  // refresh busy window lasts exactly the recovery count; a read samples
  // three edges after its call, so the two reads straddle the last busy cycle
  task automatic t_refresh_window;
    pulse_done(1'b0, 4'h0, 1'b1);
    repeat (int'(tcfg.auto_refresh_recovery) - 3) @(posedge pclk);
    rdchk(IDX_REFRESH_IN_PROGRESS, 32'h1);
    pulse_done(1'b0, 4'h0, 1'b1);
    repeat (int'(tcfg.auto_refresh_recovery) - 2) @(posedge pclk);
    rdchk(IDX_REFRESH_IN_PROGRESS, 32'h0);
  endtask : t_refresh_window

  // self-refresh held until software clears, plus status levels
  task automatic t_self_refresh;
    apb(1'b1, IDX_SELF_REFRESH_REQUEST, 32'hf);
    repeat (3) @(posedge pclk);
    chk("self req on", {31'h0, cmd.self_refresh_req}, 32'h1);
    st.self_refresh_state <= 1'b1;
    st.powerdown_active   <= 1'b1;
    rdchk(IDX_SELF_REFRESH_ACTIVE, 32'h1);
    rdchk(IDX_POWER_DOWN_ACTIVE, 32'h1);
    repeat (10) @(posedge pclk);
    chk("self req held", {31'h0, cmd.self_refresh_req}, 32'h1);
    apb(1'b1, IDX_SELF_REFRESH_REQUEST, 32'h0);
    repeat (3) @(posedge pclk);
    chk("self req off", {31'h0, cmd.self_refresh_req}, 32'h0);
    st.self_refresh_state <= 1'b0;
    st.powerdown_active   <= 1'b0;
    rdchk(IDX_SELF_REFRESH_ACTIVE, 32'h0);
    rdchk(IDX_POWER_DOWN_ACTIVE, 32'h0);
  endtask : t_self_refresh

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    st = '0;
    n_fail = 0;
    total_checks = 0;
    tcfg = 160'h1234_5678_9abc_def0_2468_ace1_3579_bdf0_0f1e_2d3c;
    tcfg.auto_refresh_recovery = 8'h14;
    gcfg = 19'h5a5a3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_readonly();
    t_moderegister();
    t_rank_refresh();
    t_refresh_window();
    t_self_refresh();
    wrap_up();
  end

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #(40 * 20000);
    n_fail++;
    wrap_up();
  end
endmodule : dcs_sideband_regs_tb_top
